// ### src/hphc_ctrl.sv
// Heating-side sequencer: compressor, four-way valve, fans, deice, auto mode.
// Assumes sensor inputs synchronous to clock; cooling logic lives elsewhere.
`timescale 1ns/1ps
`include "hphc_defines.svh"

module hphc_ctrl #(
    parameter int TICK_CYC = `HPHC_TICK_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic unit_on,
    input hphc_pkg::hphc_mode_t mode_sel,
    input wire logic fan_auto,
    input hphc_pkg::hphc_fan_t fan_manual,
    input hphc_pkg::hphc_adj_t temp_adj,
    input wire logic signed [7:0] set_temp,
    input wire logic cool_running,
    input hphc_pkg::hphc_sense_t sense,
    output hphc_pkg::hphc_act_t act
);

    // **********************************
    // Helpers
    // **********************************
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    function automatic logic signed [7:0] std_set(input hphc_pkg::hphc_mode_t m);
        case (m)
            hphc_pkg::mode_cool: std_set = `HPHC_SET_COOL_T;
            hphc_pkg::mode_dry: std_set = `HPHC_SET_DRY_T;
            default: std_set = `HPHC_SET_HEAT_T;
        endcase
    endfunction

    function automatic logic [15:0] td_of(input logic [15:0] t);
        if (t <= `HPHC_SEC(`HPHC_TD1_MIN)) begin
            td_of = 16'h0000;
        end else if (t <= `HPHC_SEC(`HPHC_TD2_MIN)) begin
            td_of = `HPHC_TD1_S;
        end else if (t <= `HPHC_SEC(`HPHC_TD3_MIN)) begin
            td_of = `HPHC_TD2_S;
        end else begin
            td_of = `HPHC_TD3_S;
        end
    endfunction

    // **********************************
    // One-second tick
    // **********************************
    logic [27:0] tick_cnt_reg;
    logic tick;

    assign tick = (tick_cnt_reg == 28'(TICK_CYC - 1));

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_reg <= 28'h000_0000;
        end else if (tick) begin
            tick_cnt_reg <= 28'h000_0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 28'h000_0001;
        end
    end

    // **********************************
    // Automatic mode selection
    // **********************************
    typedef enum logic [1:0] {auto_idle, auto_judge, auto_fixed} hphc_auto_t;
    hphc_auto_t auto_state_reg;
    hphc_pkg::hphc_mode_t fixed_mode_reg;
    logic [15:0] judge_sec_reg;
    logic was_cool_reg;
    logic is_auto;
    hphc_pkg::hphc_mode_t judged;

    assign is_auto = unit_on && (mode_sel == hphc_pkg::mode_auto);

    always_comb begin
        if (sense.intake_temp >= `HPHC_AUTO_COOL_T) begin
            judged = hphc_pkg::mode_cool;
        end else if (sense.intake_temp >= `HPHC_AUTO_DRY_T) begin
            judged = hphc_pkg::mode_dry;
        end else begin
            judged = hphc_pkg::mode_heat;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            auto_state_reg <= auto_idle;
            fixed_mode_reg <= hphc_pkg::mode_heat;
            judge_sec_reg <= 16'h0000;
            was_cool_reg <= 1'b0;
        end else if (!is_auto) begin
            auto_state_reg <= auto_idle;
        end else begin
            case (auto_state_reg)
                auto_idle: begin
                    auto_state_reg <= auto_judge;
                    judge_sec_reg <= 16'h0000;
                    was_cool_reg <= cool_running;
                end
                auto_judge: begin
                    if (sense.intake_temp < `HPHC_AUTO_HEAT_NOW_T) begin
                        auto_state_reg <= auto_fixed;
                        fixed_mode_reg <= hphc_pkg::mode_heat;
                    end else if (judge_sec_reg >= `HPHC_JUDGE_S) begin
                        auto_state_reg <= auto_fixed;
                        fixed_mode_reg <= judged;
                    end else if (tick) begin
                        judge_sec_reg <= sat_inc(judge_sec_reg);
                    end
                end
                auto_fixed: auto_state_reg <= auto_fixed;
                default: auto_state_reg <= auto_idle;
            endcase
        end
    end

    // **********************************
    // Effective mode and set point
    // **********************************
    logic judging;
    logic heat_act;
    hphc_pkg::hphc_mode_t eff_mode;
    logic signed [7:0] set_eff;
    logic thermo;
    logic signed [8:0] dt;

    assign judging = is_auto && (auto_state_reg != auto_fixed);
    assign eff_mode = is_auto ? fixed_mode_reg : mode_sel;
    assign heat_act = unit_on && !judging && (eff_mode == hphc_pkg::mode_heat);

    always_comb begin
        set_eff = set_temp;
        if (is_auto) begin
            case (temp_adj)
                hphc_pkg::adj_higher: set_eff = std_set(fixed_mode_reg) + `HPHC_ADJ_T;
                hphc_pkg::adj_lower: set_eff = std_set(fixed_mode_reg) - `HPHC_ADJ_T;
                default: set_eff = std_set(fixed_mode_reg);
            endcase
        end
    end

    assign thermo = (sense.intake_temp >= set_eff);
    assign dt = {sense.hx_temp[7], sense.hx_temp} - {sense.intake_temp[7], sense.intake_temp};

    // **********************************
    // Edge detection
    // **********************************
    logic unit_on_d_reg;
    logic heat_d_reg;
    logic on_rise;
    logic heat_rise;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            unit_on_d_reg <= 1'b0;
            heat_d_reg <= 1'b0;
        end else begin
            unit_on_d_reg <= unit_on;
            heat_d_reg <= heat_act;
        end
    end

    assign on_rise = unit_on && !unit_on_d_reg;
    assign heat_rise = heat_act && !heat_d_reg;

    // **********************************
    // Compressor timers
    // **********************************
    logic comp_reg;
    logic deice_reg;
    logic deice_end;
    logic [15:0] wait_reg;
    logic [15:0] off_sec_reg;
    logic [15:0] run_sec_reg;
    logic [15:0] rev_sec_reg;
    logic rev_trip;
    logic hx_trip;

    assign hx_trip = (sense.hx_temp >= `HPHC_TRIP_T);
    assign rev_trip = (rev_sec_reg >= `HPHC_SEC(`HPHC_REV_HOLD_MIN));

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            off_sec_reg <= 16'h0000;
            run_sec_reg <= 16'h0000;
            rev_sec_reg <= 16'h0000;
        end else begin
            if (comp_reg || on_rise) begin
                off_sec_reg <= 16'h0000;
            end else if (tick) begin
                off_sec_reg <= sat_inc(off_sec_reg);
            end
            if (!comp_reg) begin
                run_sec_reg <= 16'h0000;
            end else if (tick) begin
                run_sec_reg <= sat_inc(run_sec_reg);
            end
            if (!(comp_reg && run_sec_reg >= `HPHC_SEC(`HPHC_REV_RUN_MIN)
                    && dt <= `HPHC_REV_DT)) begin
                rev_sec_reg <= 16'h0000;
            end else if (tick) begin
                rev_sec_reg <= sat_inc(rev_sec_reg);
            end
        end
    end

    // **********************************
    // Compressor control
    // **********************************
    // Power-up counts as power return, so the first start also waits.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            comp_reg <= 1'b0;
            wait_reg <= `HPHC_SEC(`HPHC_RESTART_MIN);
        end else if (!heat_act) begin
            comp_reg <= 1'b0;
            if (comp_reg || on_rise) begin
                wait_reg <= `HPHC_SEC(`HPHC_RESTART_MIN);
            end
        end else if (on_rise) begin
            wait_reg <= `HPHC_SEC(`HPHC_RESTART_MIN);
        end else if (deice_end) begin
            comp_reg <= 1'b0;
            wait_reg <= `HPHC_POST_COMP_S;
        end else if (deice_reg) begin
            comp_reg <= comp_reg;
        end else if (comp_reg && (thermo || hx_trip || rev_trip)) begin
            comp_reg <= 1'b0;
            wait_reg <= `HPHC_SEC(`HPHC_THERMO_MIN);
        end else if (!comp_reg && !thermo && off_sec_reg >= wait_reg) begin
            comp_reg <= 1'b1;
        end
    end

    // **********************************
    // Outdoor fan overload
    // **********************************
    logic ovl_reg;
    logic ofan_on;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ovl_reg <= 1'b0;
        end else if (!heat_act || sense.hx_temp <= `HPHC_OFAN_ON_T) begin
            ovl_reg <= 1'b0;
        end else if (sense.hx_temp >= `HPHC_OFAN_OFF_T) begin
            ovl_reg <= 1'b1;
        end
    end

    assign ofan_on = comp_reg && !ovl_reg && !deice_reg;

    // **********************************
    // Deice triggers
    // **********************************
    logic [15:0] det_sec_reg;
    logic [15:0] det_lim_reg;
    logic [15:0] pipe_sec_reg;
    logic [15:0] ovl_acc_reg;
    logic det_en;
    logic deice_start;
    logic pipe_closed;

    assign pipe_closed = sense.outdoor_pipe_thermal_switch;
    assign det_en = (det_sec_reg >= det_lim_reg);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            det_sec_reg <= 16'h0000;
            det_lim_reg <= `HPHC_SEC(`HPHC_DET_FIRST_MIN);
            pipe_sec_reg <= 16'h0000;
            ovl_acc_reg <= 16'h0000;
        end else begin
            if (heat_rise) begin
                det_sec_reg <= 16'h0000;
                det_lim_reg <= `HPHC_SEC(`HPHC_DET_FIRST_MIN);
            end else if (deice_end) begin
                det_sec_reg <= 16'h0000;
                det_lim_reg <= `HPHC_SEC(`HPHC_DET_NEXT_MIN);
            end else if (heat_act && !deice_reg && tick) begin
                det_sec_reg <= sat_inc(det_sec_reg);
            end
            // Switch is blind while the outdoor fan stands still
            if (!(det_en && ofan_on && pipe_closed)) begin
                pipe_sec_reg <= 16'h0000;
            end else if (tick) begin
                pipe_sec_reg <= sat_inc(pipe_sec_reg);
            end
            if (deice_start || !heat_act) begin
                ovl_acc_reg <= 16'h0000;
            end else if (ovl_reg && tick) begin
                ovl_acc_reg <= sat_inc(ovl_acc_reg);
            end
        end
    end

    assign deice_start = heat_act && comp_reg && !deice_reg
        && ((pipe_sec_reg >= `HPHC_PIPE_S)
        || (ovl_acc_reg >= `HPHC_SEC(`HPHC_OVL_ACC_MIN)
        && run_sec_reg >= `HPHC_SEC(`HPHC_OVL_RUN_MIN)));

    // **********************************
    // Deice run and end delay
    // **********************************
    logic [15:0] dei_sec_reg;
    logic [15:0] td_reg;
    logic [15:0] td_sec_reg;
    logic open_seen_reg;
    logic [15:0] post_dei_sec_reg;

    assign deice_end = deice_reg && heat_act
        && (dei_sec_reg >= `HPHC_SEC(`HPHC_DEICE_MAX_MIN)
        || (dei_sec_reg >= `HPHC_DEICE_MIN_S
        && open_seen_reg && td_sec_reg >= td_reg));

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            deice_reg <= 1'b0;
            dei_sec_reg <= 16'h0000;
            open_seen_reg <= 1'b0;
            td_reg <= 16'h0000;
            td_sec_reg <= 16'h0000;
        end else if (!heat_act || deice_end) begin
            deice_reg <= 1'b0;
        end else if (deice_start) begin
            deice_reg <= 1'b1;
            dei_sec_reg <= 16'h0000;
            open_seen_reg <= 1'b0;
            td_sec_reg <= 16'h0000;
        end else if (deice_reg) begin
            if (!open_seen_reg && !pipe_closed) begin
                open_seen_reg <= 1'b1;
                td_reg <= td_of(dei_sec_reg);
            end
            if (tick) begin
                dei_sec_reg <= sat_inc(dei_sec_reg);
                if (open_seen_reg) begin
                    td_sec_reg <= sat_inc(td_sec_reg);
                end
            end
        end
    end

    // Starts saturated so power-up shows no post-deice hold
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            post_dei_sec_reg <= 16'hFFFF;
        end else if (deice_end) begin
            post_dei_sec_reg <= 16'h0000;
        end else if (tick) begin
            post_dei_sec_reg <= sat_inc(post_dei_sec_reg);
        end
    end

    // **********************************
    // Four-way valve and hot start
    // **********************************
    logic heated_reg;
    logic [15:0] post_heat_sec_reg;
    logic hot_reg;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            heated_reg <= 1'b0;
            post_heat_sec_reg <= 16'h0000;
        end else if (heat_act) begin
            heated_reg <= 1'b1;
            post_heat_sec_reg <= 16'h0000;
        end else begin
            if (post_heat_sec_reg >= `HPHC_SEC(`HPHC_VALVE_HOLD_MIN)) begin
                heated_reg <= 1'b0;
            end
            if (tick) begin
                post_heat_sec_reg <= sat_inc(post_heat_sec_reg);
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hot_reg <= 1'b0;
        end else if (heat_rise || deice_end) begin
            hot_reg <= 1'b1;
        end else if (!heat_act || sense.hx_temp >= `HPHC_HOT_END_T) begin
            hot_reg <= 1'b0;
        end
    end

    // **********************************
    // Indoor fan
    // **********************************
    hphc_pkg::hphc_fan_t auto_fan;
    hphc_pkg::hphc_fan_t fan_next;

    always_comb begin
        if (sense.hx_temp >= `HPHC_AFAN_ME_T) begin
            auto_fan = hphc_pkg::medium_fan_speed;
        end else if (sense.hx_temp >= `HPHC_AFAN_LO_T) begin
            auto_fan = hphc_pkg::low_fan_speed;
        end else begin
            auto_fan = hphc_pkg::super_low_fan_speed;
        end
    end

    always_comb begin
        fan_next = fan_auto ? auto_fan : fan_manual;
        if (!unit_on) begin
            fan_next = hphc_pkg::fan_off;
        end else if (judging) begin
            fan_next = hphc_pkg::super_low_fan_speed;
        end else if (!heat_act) begin
            fan_next = fan_manual;
        end else if (deice_reg) begin
            fan_next = hphc_pkg::fan_off;
        end else if (hot_reg) begin
            fan_next = (sense.hx_temp < `HPHC_HOT_FAN_T) ? hphc_pkg::fan_off
                : hphc_pkg::super_low_fan_speed;
        end else if (!comp_reg && off_sec_reg >= `HPHC_SEC(`HPHC_FSTOP_AT_MIN)) begin
            fan_next = (off_sec_reg < `HPHC_SEC(`HPHC_FSTOP_AT_MIN + `HPHC_FSTOP_LEN_MIN))
                ? hphc_pkg::fan_off : hphc_pkg::super_low_fan_speed;
        end
    end

    // **********************************
    // Output register
    // **********************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            act <= '0;
        end else begin
            act.compressor_on <= comp_reg;
            act.valve_heat <= heated_reg && !deice_reg
                && (post_dei_sec_reg >= `HPHC_POST_VALVE_S);
            act.outdoor_fan_on <= ofan_on;
            act.indoor_fan <= fan_next;
            act.deice_active <= deice_reg;
            act.keep_cooling <= judging && was_cool_reg;
            act.op_mode <= eff_mode;
        end
    end

endmodule

// ### src/hphc_defines.svh
// Constants of the heat pump heating controller: temperatures, times, counts.
// Assumes a 200 MHz clock; all timers step on a one-second tick.
//
// Summary of operation
// - After unit on or power return, compressor waits 3 minutes.
// - Room at set temperature stops compressor; no restart for 4 minutes.
// - 3 minutes after compressor stop, indoor fan off 1 minute, then super low.
// - Outdoor fan off at exchanger 51 C, back on at 49 C.
// - Exchanger at 65 C or more stops compressor; restart after 4 minute wait.
// - Run 5 minutes and exchanger-intake 5 C or less for 2 minutes stops it.
// - Four-way valve energised throughout heating, except during deice and for 10 s after it.
// - Unit switched off in heating keeps valve in heating position 5 minutes.
// - Heating start keeps indoor fan off until exchanger reaches 30 C.
// - Hot start ends when exchanger reaches 41 C.
// - Automatic fan speed picks medium to super low from exchanger temperature.
// - Frost detection enabled 30 minutes after heating start, 60 after deice.
// - Pipe switch closed 50 s with outdoor fan running starts deice.
// - Overload fan-off time of 60 minutes plus 1 minute run starts deice.
// - Any deice ends at most 12 minutes after it began.
// - Deice end delay after pipe switch opens: 0, 60, 120 or 180 s.
// - A deice runs at least 60 seconds.
// - After deice compressor off 30 s, valve in cooling position 10 s.
// - Automatic mode runs super low fan 20 s, then judges and fixes mode.
// - Automatic mode picks heating at once below 16 C intake.
// - The fixed automatic mode never changes afterwards.
// - Auto chosen while cooling keeps cooling at super low for 20 s.
// - Automatic set temperature shifted by +2, 0 or -2 C.
`ifndef HPHC_DEFINES_SVH
`define HPHC_DEFINES_SVH

`define HPHC_CLK_HZ 200000000
`define HPHC_TICK_S 1
`define HPHC_TICK_CYC (`HPHC_CLK_HZ * `HPHC_TICK_S)
`define HPHC_SEC(m) 16'((m) * 60)

`define HPHC_RESTART_MIN 3
`define HPHC_THERMO_MIN 4
`define HPHC_FSTOP_AT_MIN 3
`define HPHC_FSTOP_LEN_MIN 1
`define HPHC_REV_RUN_MIN 5
`define HPHC_REV_HOLD_MIN 2
`define HPHC_VALVE_HOLD_MIN 5
`define HPHC_DET_FIRST_MIN 30
`define HPHC_DET_NEXT_MIN 60
`define HPHC_OVL_ACC_MIN 60
`define HPHC_OVL_RUN_MIN 1
`define HPHC_DEICE_MAX_MIN 12
`define HPHC_TD1_MIN 3
`define HPHC_TD2_MIN 6
`define HPHC_TD3_MIN 9
`define HPHC_TD1_S 16'd60
`define HPHC_TD2_S 16'd120
`define HPHC_TD3_S 16'd180
`define HPHC_PIPE_S 16'd50
`define HPHC_DEICE_MIN_S 16'd60
`define HPHC_POST_COMP_S 16'd30
`define HPHC_POST_VALVE_S 16'd10
`define HPHC_JUDGE_S 16'd20

`define HPHC_OFAN_OFF_T 8'sd51
`define HPHC_OFAN_ON_T 8'sd49
`define HPHC_TRIP_T 8'sd65
`define HPHC_REV_DT 9'sd5
`define HPHC_HOT_FAN_T 8'sd30
`define HPHC_HOT_END_T 8'sd41
`define HPHC_AFAN_ME_T 8'sd40
`define HPHC_AFAN_LO_T 8'sd35
`define HPHC_AUTO_HEAT_NOW_T 8'sd16
`define HPHC_AUTO_COOL_T 8'sd23
`define HPHC_AUTO_DRY_T 8'sd20
`define HPHC_SET_COOL_T 8'sd25
`define HPHC_SET_DRY_T 8'sd22
`define HPHC_SET_HEAT_T 8'sd21
`define HPHC_ADJ_T 8'sd2

`endif

// ### src/hphc_pkg.sv
// Types of the heat pump heating controller.
// Assumes temperatures arrive as signed whole degrees Celsius.
package hphc_pkg;
    typedef enum logic [1:0] {mode_cool, mode_dry, mode_heat, mode_auto} hphc_mode_t;
    typedef enum logic [1:0] {
        fan_off, super_low_fan_speed, low_fan_speed, medium_fan_speed
    } hphc_fan_t;
    typedef enum logic [1:0] {adj_standard, adj_higher, adj_lower} hphc_adj_t;
    typedef struct packed {
        logic signed [7:0] hx_temp;
        logic signed [7:0] intake_temp;
        logic outdoor_pipe_thermal_switch;
    } hphc_sense_t;
    typedef struct packed {
        logic compressor_on;
        logic valve_heat;
        logic outdoor_fan_on;
        hphc_fan_t indoor_fan;
        logic deice_active;
        logic keep_cooling;
        hphc_mode_t op_mode;
    } hphc_act_t;
endpackage

// ### verif/hphc_ctrl_checker.sv
// Port checker for the heating controller.
// Assumes it is bound into hphc_ctrl with the same TICK_CYC.
`timescale 1ns/1ps
module hphc_ctrl_checker #(
    parameter int TICK_CYC = 4
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic unit_on,
    input hphc_pkg::hphc_sense_t sense,
    input hphc_pkg::hphc_act_t act
);
    // ****************
    // Helper counters
    // ****************
    int on_cnt;
    int dei_cnt;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Time since switch-on, also since reset release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            on_cnt <= 0;
        end else begin
            on_cnt <= unit_on ? on_cnt + 1 : 0;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dei_cnt <= 0;
        end else begin
            dei_cnt <= act.deice_active ? dei_cnt + 1 : 0;
        end
    end
    restart_wait_a: assert property (
        act.compressor_on && unit_on && $past(unit_on, 2) |-> on_cnt >= 179 * TICK_CYC)
        else $error("compressor started inside the power-on wait");
    ofan_hot_a: assert property (
        sense.hx_temp >= 8'sh33 [*3] |-> !act.outdoor_fan_on)
        else $error("outdoor fan runs on a hot exchanger");
    trip_stop_a: assert property (
        (sense.hx_temp >= 8'sh41 && !act.deice_active) [*3] |-> !act.compressor_on)
        else $error("compressor runs above trip temperature");
    valve_heat_a: assert property (
        act.compressor_on && !act.deice_active && act.op_mode == hphc_pkg::mode_heat
        |-> act.valve_heat)
        else $error("valve released while heating");
    valve_hold_a: assert property (
        $fell(unit_on) && act.valve_heat |-> act.valve_heat [*8])
        else $error("valve released at switch-off");
    deice_outputs_a: assert property (
        act.deice_active |-> !act.outdoor_fan_on && !act.valve_heat
        && act.indoor_fan == hphc_pkg::fan_off)
        else $error("fan or valve wrong during deice");
    deice_max_a: assert property (
        dei_cnt <= 721 * TICK_CYC + 2)
        else $error("deice longer than its limit");
    deice_min_a: assert property (
        $fell(act.deice_active) && unit_on |-> dei_cnt >= 59 * TICK_CYC)
        else $error("deice shorter than its minimum");
    post_comp_a: assert property (
        $fell(act.deice_active) && unit_on |-> !act.compressor_on [*8])
        else $error("compressor on right after deice");
endmodule

bind hphc_ctrl hphc_ctrl_checker #(.TICK_CYC(TICK_CYC)) i_chk (.clock(clock), .nrst(nrst),
    .unit_on(unit_on), .sense(sense), .act(act));

// ### verif/hphc_plant.sv
// Plant model: exchanger temperature follows the heating actuators.
// Assumes the bench sets intake, peak temperature and pipe switch.
`timescale 1ns/1ps
module hphc_plant (
    input wire logic clock,
    input hphc_pkg::hphc_act_t act,
    input wire logic signed [7:0] intake,
    input wire logic signed [7:0] peak,
    input wire logic pipe_closed,
    output hphc_pkg::hphc_sense_t sense
);
    logic [3:0] div = 4'h0;
    logic signed [7:0] hx = 8'sh14;
    logic heat;
    assign heat = act.compressor_on && act.valve_heat;
    // One degree per 16 clocks, so thresholds are crossed slowly
    always @(posedge clock) begin
        div <= div + 4'h1;
        if (div == 4'h0) begin
            if (heat && hx < peak)
                hx <= hx + 8'sh01;
            else if (hx > peak || (!heat && hx > intake))
                hx <= hx - 8'sh01;
        end
    end
    assign sense = '{hx_temp: hx, intake_temp: intake, outdoor_pipe_thermal_switch: pipe_closed};
endmodule

// ### verif/hphc_ctrl_tb.sv
// Self-checking bench for the heating controller with a plant model.
// Assumes a short tick so minute timers fit a few thousand cycles.
`timescale 1ns/1ps
module hphc_ctrl_tb;
    localparam int TC = 4;
    logic clock, nrst, unit_on, fan_auto, cool_running, pipe_closed;
    logic signed [7:0] set_temp, intake, peak;
    logic [19:0] seed;
    hphc_pkg::hphc_mode_t mode_sel;
    hphc_pkg::hphc_fan_t fan_manual;
    hphc_pkg::hphc_adj_t temp_adj;
    hphc_pkg::hphc_sense_t sense;
    hphc_pkg::hphc_act_t act;
    int err_count, compares, n;
    hphc_ctrl #(.TICK_CYC(TC)) i_dut (.clock(clock), .nrst(nrst), .unit_on(unit_on),
        .mode_sel(mode_sel), .fan_auto(fan_auto), .fan_manual(fan_manual),
        .temp_adj(temp_adj), .set_temp(set_temp), .cool_running(cool_running),
        .sense(sense), .act(act));
    hphc_plant i_plant (.clock(clock), .act(act), .intake(intake), .peak(peak),
        .pipe_closed(pipe_closed), .sense(sense));
    always #2.5 clock = ~clock;
    function automatic logic [19:0] lfsr(input logic [19:0] s);
        return {s[18:0], s[19] ^ s[16]};
    endfunction
    // Extra deice time after the pipe switch opens, in ticks
    function automatic int td_of(input int t);
        return t <= 180 ? 0 : t <= 360 ? 60 : t <= 540 ? 120 : 180;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ticks(input int k);
        repeat (k * TC) @(posedge clock);
        #1;
    endtask
    task automatic test_done;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Hang guard, about twice the expected run
    initial begin
        repeat (60000) @(posedge clock);
        err_count++;
        test_done;
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        unit_on = 1'b0;
        fan_auto = 1'b1;
        cool_running = 1'b0;
        pipe_closed = 1'b0;
        intake = 8'sh12;
        peak = 8'sh2d;
        seed = lfsr(20'h1_6605);
        set_temp = 8'sh18 + 8'(seed[2:0]);
        mode_sel = hphc_pkg::mode_heat;
        fan_manual = hphc_pkg::low_fan_speed;
        temp_adj = hphc_pkg::hphc_adj_t'({1'b0, seed[3]});
        err_count = 0;
        compares = 0;
        repeat (12) @(posedge clock);
        #1 nrst = 1'b1;
        @(posedge clock);
        #1 unit_on = 1'b1;
        ticks(100);
        check(act.compressor_on, 0);
        check(act.valve_heat, 1);
        for (n = 0; n < 100 && !act.compressor_on; n++) ticks(1);
        check(n >= 78 && n <= 82, 1);
        ticks(10);
        check(act.indoor_fan, hphc_pkg::fan_off);
        ticks(150);
        check(act.indoor_fan, hphc_pkg::medium_fan_speed);
        check(act.outdoor_fan_on, 1);
        peak = 8'sh34;
        ticks(40);
        check(act.outdoor_fan_on, 0);
        peak = 8'sh2d;
        ticks(40);
        check(act.outdoor_fan_on, 1);
        peak = 8'sh42;
        for (n = 0; n < 200 && act.compressor_on; n++) ticks(1);
        peak = 8'sh2d;
        ticks(200);
        check(act.indoor_fan, hphc_pkg::fan_off);
        ticks(30);
        check(act.compressor_on, 0);
        ticks(20);
        check(act.compressor_on, 1);
        pipe_closed = 1'b1;
        for (n = 0; n < 1500 && !act.deice_active; n++) ticks(1);
        check(n > 700 && n < 1500, 1);
        ticks(400);
        pipe_closed = 1'b0;
        for (n = 0; n < 300 && act.deice_active; n++) ticks(1);
        check(n >= td_of(400) - 3 && n <= td_of(400) + 3, 1);
        check(act.compressor_on, 0);
        ticks(20);
        check(act.compressor_on, 0);
        check(act.valve_heat, 1);
        ticks(15);
        check(act.compressor_on, 1);
        pipe_closed = 1'b1;
        for (n = 0; n < 4000 && !act.deice_active; n++) ticks(1);
        check(n > 3500, 1);
        for (n = 0; n < 800 && act.deice_active; n++) ticks(1);
        check(n >= 715 && n <= 722, 1);
        pipe_closed = 1'b0;
        ticks(40);
        unit_on = 1'b0;
        ticks(200);
        check(act.valve_heat, 1);
        ticks(110);
        check(act.valve_heat, 0);
        mode_sel = hphc_pkg::mode_auto;
        intake = 8'sh0a + 8'(seed[5:4]);
        unit_on = 1'b1;
        ticks(5);
        check(act.op_mode, hphc_pkg::mode_heat);
        check(act.indoor_fan, hphc_pkg::fan_off);
        unit_on = 1'b0;
        ticks(2);
        intake = 8'sh15;
        cool_running = 1'b1;
        unit_on = 1'b1;
        ticks(10);
        check(act.indoor_fan, hphc_pkg::super_low_fan_speed);
        check(act.keep_cooling, 1);
        ticks(15);
        check(act.op_mode, hphc_pkg::mode_dry);
        check(act.keep_cooling, 0);
        intake = 8'sh0a;
        ticks(5);
        check(act.op_mode, hphc_pkg::mode_dry);
        test_done;
    end
endmodule
